// ### pkg/psw_pkg.sv
// Types shared by the card power switch block.
package psw_pkg;

    typedef enum logic [4:0] {
        PSW_ST_IDLE      = 5'b00001,
        PSW_ST_DATA_LOW  = 5'b00010,
        PSW_ST_DATA_HIGH = 5'b00100,
        PSW_ST_LATCH_SET = 5'b01000,
        PSW_ST_LATCH_CLR = 5'b10000
    } psw_state_e;

    typedef logic [10:0] psw_word_t;

endpackage

// ### pkg/psw_regs.svh
// Register offsets, field positions, reset values and timing counts of the card power switch block.
`ifndef PSW_REGS_SVH
`define PSW_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PSW_OFF_GEN_CTRL        8'h00
`define PSW_OFF_POWER_REQ       8'h04
`define PSW_OFF_LINK_STATUS     8'h08
`define PSW_OFF_PRESENT_STATE   8'h0C

// ----------------------------------------------------------------------------
// General control fields
// ----------------------------------------------------------------------------
`define PSW_GC_RESEND_BIT       0
`define PSW_GC_VARIANT_BIT      10
`define PSW_GC_RESET            32'h0000_0000

// ----------------------------------------------------------------------------
// Power request fields
// ----------------------------------------------------------------------------
`define PSW_PR_A_VCC_LSB        0
`define PSW_PR_A_VPP_LSB        2
`define PSW_PR_B_VCC_LSB        8
`define PSW_PR_B_VPP_LSB        10
`define PSW_PR_SUPPLY_SHUTDOWN_N_N_BIT       16
`define PSW_PR_MASK             32'h0001_1F1F
`define PSW_PR_RESET            32'h0000_0000

// ----------------------------------------------------------------------------
// Link status and present state fields
// ----------------------------------------------------------------------------
`define PSW_LS_BUSY_BIT         31
`define PSW_LS_PENDING_BIT      30
`define PSW_LS_REQ_WORD_LSB     16
`define PSW_LS_SENT_WORD_LSB    0
`define PSW_PS_LOW_V_LSB        0
`define PSW_PS_EXTRA_V_LSB      2
`define PSW_PS_DET_1V8_LSB      4
`define PSW_PS_DET_3V3_LSB      6

// ----------------------------------------------------------------------------
// Link word layout and timing
// ----------------------------------------------------------------------------
`define PSW_WORD_BITS           11
`define PSW_PCLK_MHZ            20
`define PSW_HALF_PERIOD_NS      1000
`define PSW_HALF_CYC            ((`PSW_HALF_PERIOD_NS * `PSW_PCLK_MHZ + 999) / 1000)

`endif

// ### sim/psw_card_power_monitor.sv
// Concurrent checks on the ports of the card power switch block.
`timescale 1ns/100ps

module psw_card_power_monitor #(
    parameter int ADDR_W   = 8,
    parameter int HALF_CYC = 20
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [1:0]        card_det_3v3,
    input wire logic [1:0]        card_det_1v8,
    input wire logic              ser_data,
    input wire logic              ser_clock,
    input wire logic              ser_latch
);
    logic [7:0] hi_cnt;
    logic [7:0] lat_cnt;
    logic [3:0] bit_cnt;
    logic       clk_q;
    logic       lat_q;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Counts high time of link clock and latch, and clock rises since the last latch.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt  <= 8'h00;
            lat_cnt <= 8'h00;
            bit_cnt <= 4'h0;
            clk_q   <= 1'b0;
            lat_q   <= 1'b0;
        end else begin
            hi_cnt  <= ser_clock ? hi_cnt + 8'h01 : 8'h00;
            lat_cnt <= ser_latch ? lat_cnt + 8'h01 : 8'h00;
            clk_q   <= ser_clock;
            lat_q   <= ser_latch;
            if (ser_latch && !lat_q) begin
                bit_cnt <= 4'h0;
            end else if (ser_clock && !clk_q) begin
                bit_cnt <= bit_cnt + 4'h1;
            end
        end
    end

    AST_READY_ONE_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not after exactly one wait state");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside an answer");
    AST_LATCH_NO_CLOCK: assert property (ser_latch |-> !ser_clock)
        else $error("link clock high while latch high");
    AST_DATA_STABLE: assert property (ser_clock |-> $stable(ser_data))
        else $error("link data changed while clock high");
    AST_CLOCK_HIGH: assert property ($fell(ser_clock) |-> hi_cnt == 8'(HALF_CYC))
        else $error("link clock high time wrong");
    AST_LATCH_HIGH: assert property ($fell(ser_latch) |-> lat_cnt == 8'(HALF_CYC))
        else $error("latch high time wrong");
    AST_WORD_BITS: assert property ($rose(ser_latch) |-> bit_cnt == 4'hB)
        else $error("latch after wrong bit count");
    AST_NO_EXTRA_CLOCK: assert property ($rose(ser_clock) |-> bit_cnt < 4'hB)
        else $error("clock rise before latch of full word");
endmodule // psw_card_power_monitor

bind psw_card_power psw_card_power_monitor #(.ADDR_W(ADDR_W), .HALF_CYC(HALF_CYC)) i_psw_card_power_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .card_det_3v3(card_det_3v3),
    .card_det_1v8(card_det_1v8), .ser_data(ser_data), .ser_clock(ser_clock), .ser_latch(ser_latch));

// ### sim/psw_switch_model.sv
// Behavioural model of the serial power switch on the far side of the link.
`timescale 1ns/100ps

module psw_switch_model (
    input  wire logic         ser_data,
    input  wire logic         ser_clock,
    input  wire logic         ser_latch,
    output psw_pkg::psw_word_t word,
    output int                count
);
    psw_pkg::psw_word_t shift;
    int                 idx;

    initial begin
        word  = '0;
        shift = '0;
        count = 0;
        idx   = 0;
    end

    always @(posedge ser_clock) begin
        if (idx < 11) begin
            shift[idx] = ser_data;
        end
        idx = idx + 1;
    end

    always @(posedge ser_latch) begin
        word  = shift;
        count = count + 1;
        idx   = 0;
    end
endmodule // psw_switch_model

// ### sim/test_psw_card_power.sv
// Self-checking testbench of the card power switch block.
`timescale 1ns/100ps
`include "psw_regs.svh"

module test_psw_card_power;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic               ser_data, ser_clock, ser_latch, err;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic [1:0]         card_det_3v3, card_det_1v8;
    psw_pkg::psw_word_t m_word;
    int                 m_cnt, miscompares, checks;

    psw_card_power #(.ADDR_W(8), .HALF_CYC(4)) i_psw_card_power (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .card_det_3v3(card_det_3v3),
        .card_det_1v8(card_det_1v8), .ser_data(ser_data), .ser_clock(ser_clock), .ser_latch(ser_latch));
    psw_switch_model i_psw_switch_model (
        .ser_data(ser_data), .ser_clock(ser_clock), .ser_latch(ser_latch), .word(m_word), .count(m_cnt));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic give_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic timed_out(input string name);
        miscompares++;
        $display("unexpected %s: expected answer, seen none", name);
        give_verdict();
    endtask

    // One APB transfer; read data and error land in rd and err.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) timed_out("pready");
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_word();
        int c0;
        int n;
        c0 = m_cnt;
        n  = 0;
        while (m_cnt == c0 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 3000) timed_out("latched word");
        while (ser_latch !== 1'b0 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 3000) timed_out("latch release");
    endtask

    function automatic logic [31:0] exp_word(input logic [31:0] r);
        return {21'h0, r[10], r[2], r[16], r[8], r[9], r[11], r[12], r[1], r[0], r[3], r[4]};
    endfunction

    task automatic t_reset();
        wait_word();
        check("reset word", {21'h0, m_word}, 32'h0000_0000);
        apb(1'b0, `PSW_OFF_GEN_CTRL, 32'h0);
        check("gen ctrl reset", rd, `PSW_GC_RESET);
        apb(1'b0, `PSW_OFF_POWER_REQ, 32'h0);
        check("power req reset", rd, `PSW_PR_RESET);
        $display("test reset done");
    endtask

    task automatic t_map();
        logic [31:0] r;
        for (int i = 0; i < 8; i++) begin
            r = {15'h0, i != 3, 3'h0, 3'(7 - i), ~2'(i), 3'h0, 3'(i), 2'(i)};
            apb(1'b1, `PSW_OFF_POWER_REQ, r);
            wait_word();
            check("link word", {21'h0, m_word}, exp_word(r));
        end
        apb(1'b0, `PSW_OFF_LINK_STATUS, 32'h0);
        check("sent word", {21'h0, rd[10:0]}, exp_word(r));
        $display("test word map done");
    endtask

    task automatic t_queue();
        apb(1'b1, `PSW_OFF_POWER_REQ, 32'h0001_1F1F);
        apb(1'b1, `PSW_OFF_POWER_REQ, 32'h0000_0C03);
        apb(1'b1, `PSW_OFF_POWER_REQ, 32'h0001_0B16);
        wait_word();
        check("first word", {21'h0, m_word}, exp_word(32'h0001_1F1F));
        wait_word();
        check("newest word", {21'h0, m_word}, exp_word(32'h0001_0B16));
        apb(1'b0, `PSW_OFF_LINK_STATUS, 32'h0);
        check("busy pending", {30'h0, rd[31:30]}, 32'h0);
        $display("test queue done");
    endtask

    task automatic t_resend();
        apb(1'b1, `PSW_OFF_POWER_REQ, 32'h0001_0B16);
        apb(1'b0, `PSW_OFF_LINK_STATUS, 32'h0);
        check("no resend", {30'h0, rd[31:30]}, 32'h0);
        apb(1'b1, `PSW_OFF_GEN_CTRL, 32'h0000_0001);
        wait_word();
        check("resent word", {21'h0, m_word}, exp_word(32'h0001_0B16));
        $display("test resend done");
    endtask

    task automatic t_flags();
        card_det_1v8 <= 2'h1;
        card_det_3v3 <= 2'h2;
        apb(1'b1, `PSW_OFF_GEN_CTRL, 32'h0);
        repeat (4) @(posedge pclk);
        apb(1'b0, `PSW_OFF_PRESENT_STATE, 32'h0);
        check("flags variant 0", rd, 32'h0000_0093);
        apb(1'b1, `PSW_OFF_GEN_CTRL, 32'h0000_0400);
        apb(1'b0, `PSW_OFF_GEN_CTRL, 32'h0);
        check("variant select", rd, 32'h0000_0400);
        apb(1'b0, `PSW_OFF_PRESENT_STATE, 32'h0);
        check("flags variant 1", rd, 32'h0000_0096);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        $display("test flags done");
    endtask

    initial begin
        miscompares  = 0;
        checks       = 0;
        presetn      = 1'b0;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        paddr        = 8'h00;
        pwdata       = 32'h0;
        card_det_3v3 = 2'h0;
        card_det_1v8 = 2'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_map();
        t_queue();
        t_resend();
        t_flags();
        give_verdict();
    end
endmodule // test_psw_card_power

// ### src/psw_card_power.sv
// Card socket power control: APB registers, serial link to the power switch, card voltage flags.
`timescale 1ns/100ps
`include "psw_regs.svh"

module psw_card_power #(
    parameter int ADDR_W   = 8,
    parameter int HALF_CYC = `PSW_HALF_CYC
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [1:0]        card_det_3v3,
    input  wire logic [1:0]        card_det_1v8,
    output logic                   ser_data,
    output logic                   ser_clock,
    output logic                   ser_latch
);

    // ------------------------------------------------------------------------
    // Word assembly
    // ------------------------------------------------------------------------
    // Maps the socket request fields onto the switch word bit positions.
    function automatic psw_pkg::psw_word_t build_word(input logic [31:0] req);
        psw_pkg::psw_word_t w;
        w     = '0;
        w[0]  = req[`PSW_PR_A_VPP_LSB + 2];
        w[1]  = req[`PSW_PR_A_VPP_LSB + 1];
        w[9]  = req[`PSW_PR_A_VPP_LSB];
        w[3]  = req[`PSW_PR_A_VCC_LSB + 1];
        w[2]  = req[`PSW_PR_A_VCC_LSB];
        w[4]  = req[`PSW_PR_B_VPP_LSB + 2];
        w[5]  = req[`PSW_PR_B_VPP_LSB + 1];
        w[10] = req[`PSW_PR_B_VPP_LSB];
        w[6]  = req[`PSW_PR_B_VCC_LSB + 1];
        w[7]  = req[`PSW_PR_B_VCC_LSB];
        w[8]  = req[`PSW_PR_SUPPLY_SHUTDOWN_N_N_BIT];
        return w;
    endfunction

    // Decodes a register offset into a one-hot select.
    function automatic logic [3:0] decode_addr(input logic [ADDR_W-1:0] a);
        logic [3:0] s;
        s    = 4'h0;
        s[0] = (a == ADDR_W'(`PSW_OFF_GEN_CTRL));
        s[1] = (a == ADDR_W'(`PSW_OFF_POWER_REQ));
        s[2] = (a == ADDR_W'(`PSW_OFF_LINK_STATUS));
        s[3] = (a == ADDR_W'(`PSW_OFF_PRESENT_STATE));
        return s;
    endfunction

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [31:0]          gen_ctrl_r;
    logic [31:0]          power_req_r;
    logic                 pending_r;
    psw_pkg::psw_word_t   shift_r;
    psw_pkg::psw_word_t   sent_word_r;
    logic [3:0]           bit_cnt_r;
    logic [15:0]          div_cnt_r;
    psw_pkg::psw_state_e  state_r;
    logic [1:0]           low_v_flag_r;
    logic [1:0]           extra_v_flag_r;
    logic [1:0]           det_3v3_s;
    logic [1:0]           det_1v8_s;
    logic [3:0]           sel_dec;
    logic                 acc_phase;
    logic                 wr_fire;
    logic                 req_change;
    logic                 resend_req;
    logic                 take_word;
    logic                 tick;
    logic                 busy;
    logic                 switch_variant_select;
    logic [31:0]          rd_mux;
    psw_pkg::psw_state_e  state_nxt;
    psw_pkg::psw_word_t   req_word;
    logic                 answer;
    logic                 last_bit;
    logic                 clock_rise;
    logic                 clock_fall;
    logic                 latch_rise;
    logic                 latch_fall;
    logic                 bit_step;

    assign switch_variant_select = gen_ctrl_r[`PSW_GC_VARIANT_BIT];
    assign sel_dec   = decode_addr(paddr);
    assign acc_phase = psel & penable;
    assign wr_fire   = acc_phase & pready & pwrite & ~pslverr;
    assign busy      = (state_r != psw_pkg::PSW_ST_IDLE);
    assign take_word = (state_r == psw_pkg::PSW_ST_IDLE) & pending_r;
    assign tick      = busy & (div_cnt_r == 16'(HALF_CYC - 1));
    assign answer    = acc_phase & ~pready;
    assign req_word  = build_word(power_req_r);
    assign last_bit  = (bit_cnt_r == 4'(`PSW_WORD_BITS - 1));

    // Half-period boundaries of the link, each one pclk cycle long.
    assign clock_rise = (state_r == psw_pkg::PSW_ST_DATA_LOW) & tick;
    assign clock_fall = (state_r == psw_pkg::PSW_ST_DATA_HIGH) & tick;
    assign latch_rise = (state_r == psw_pkg::PSW_ST_LATCH_SET) & tick;
    assign latch_fall = (state_r == psw_pkg::PSW_ST_LATCH_CLR) & tick;
    assign bit_step   = clock_fall & ~last_bit;

    // A power request write only starts a new word when the value really changes.
    assign req_change = wr_fire & sel_dec[1]
                      & ((pwdata & `PSW_PR_MASK) != power_req_r);
    assign resend_req = wr_fire & sel_dec[0] & pwdata[`PSW_GC_RESEND_BIT];

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    psw_sync #(
        .WIDTH    (4)
    ) u_det_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({card_det_1v8, card_det_3v3}),
        .sync_out ({det_1v8_s, det_3v3_s})
    );

    // ------------------------------------------------------------------------
    // APB slave handshake
    // ------------------------------------------------------------------------
    // One wait state: pready rises with data on the first access-phase edge, so the transfer ends on the second.
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (1'b1)
            sel_dec[0]: rd_mux = gen_ctrl_r;
            sel_dec[1]: rd_mux = power_req_r;
            sel_dec[2]: begin
                rd_mux[`PSW_LS_BUSY_BIT]    = busy;
                rd_mux[`PSW_LS_PENDING_BIT] = pending_r;
                rd_mux[`PSW_LS_REQ_WORD_LSB +: `PSW_WORD_BITS]  = req_word;
                rd_mux[`PSW_LS_SENT_WORD_LSB +: `PSW_WORD_BITS] = sent_word_r;
            end
            sel_dec[3]: begin
                rd_mux[`PSW_PS_LOW_V_LSB +: 2]   = low_v_flag_r;
                rd_mux[`PSW_PS_EXTRA_V_LSB +: 2] = extra_v_flag_r;
                rd_mux[`PSW_PS_DET_1V8_LSB +: 2] = det_1v8_s;
                rd_mux[`PSW_PS_DET_3V3_LSB +: 2] = det_3v3_s;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= answer;
        end
    end

    // Only an address outside the four registers is refused.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= answer & (sel_dec == 4'h0);
        end
    end

    // Read data stands only with pready, so the bus reads zero otherwise.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (answer & ~pwrite) begin
            prdata <= rd_mux;
        end else begin
            prdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    // The resend bit is a write-one action and never stored.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_ctrl_r <= `PSW_GC_RESET;
        end else if (wr_fire & sel_dec[0]) begin
            gen_ctrl_r <= 32'h0000_0000;
            gen_ctrl_r[`PSW_GC_VARIANT_BIT] <= pwdata[`PSW_GC_VARIANT_BIT];
        end
    end

    // Reset value keeps the shutdown bit low so all supplies float.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_req_r <= `PSW_PR_RESET;
        end else if (wr_fire & sel_dec[1]) begin
            power_req_r <= pwdata & `PSW_PR_MASK;
        end
    end

    // A new request arriving in the cycle the word is taken keeps the flag set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_r <= 1'b1;
        end else if (req_change | resend_req) begin
            pending_r <= 1'b1;
        end else if (take_word) begin
            pending_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Half-period divider
    // ------------------------------------------------------------------------
    // Held at zero while idle so the first clock rise gets a full data setup.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= 16'h0000;
        end else if (~busy | tick) begin
            div_cnt_r <= 16'h0000;
        end else begin
            div_cnt_r <= div_cnt_r + 16'h0001;
        end
    end

    // ------------------------------------------------------------------------
    // Serial link sequencer
    // ------------------------------------------------------------------------
    // The state moves only on a divider tick, except when a new word is taken.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            psw_pkg::PSW_ST_IDLE: begin
                if (pending_r) begin
                    state_nxt = psw_pkg::PSW_ST_DATA_LOW;
                end
            end
            psw_pkg::PSW_ST_DATA_LOW: begin
                if (tick) begin
                    state_nxt = psw_pkg::PSW_ST_DATA_HIGH;
                end
            end
            psw_pkg::PSW_ST_DATA_HIGH: begin
                if (tick) begin
                    state_nxt = last_bit ? psw_pkg::PSW_ST_LATCH_SET : psw_pkg::PSW_ST_DATA_LOW;
                end
            end
            psw_pkg::PSW_ST_LATCH_SET: begin
                if (tick) begin
                    state_nxt = psw_pkg::PSW_ST_LATCH_CLR;
                end
            end
            psw_pkg::PSW_ST_LATCH_CLR: begin
                if (tick) begin
                    state_nxt = psw_pkg::PSW_ST_IDLE;
                end
            end
            default: state_nxt = psw_pkg::PSW_ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= psw_pkg::PSW_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Loads the word and steps through its bits, D0 first.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_r   <= '0;
            bit_cnt_r <= 4'h0;
            ser_data  <= 1'b0;
        end else if (take_word) begin
            shift_r   <= req_word;
            bit_cnt_r <= 4'h0;
            ser_data  <= req_word[0];
        end else if (bit_step) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            ser_data  <= shift_r[bit_cnt_r + 4'h1];
        end
    end

    // The link clock rises mid-bit and falls as the next bit is put out.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser_clock <= 1'b0;
        end else if (clock_rise) begin
            ser_clock <= 1'b1;
        end else if (clock_fall | (state_r != psw_pkg::PSW_ST_DATA_HIGH)) begin
            ser_clock <= 1'b0;
        end
    end

    // The latch rises a half period after the last clock fall, clock held low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser_latch <= 1'b0;
        end else if (latch_rise) begin
            ser_latch <= 1'b1;
        end else if (latch_fall | (state_r != psw_pkg::PSW_ST_LATCH_CLR)) begin
            ser_latch <= 1'b0;
        end
    end

    // Records the word once the latch has applied it to the switch.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sent_word_r <= '0;
        end else if (latch_rise) begin
            sent_word_r <= shift_r;
        end
    end

    // ------------------------------------------------------------------------
    // Card voltage flags
    // ------------------------------------------------------------------------
    // A 1.8 V core card lands on one flag or the other per the variant select.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_v_flag_r   <= 2'b00;
            extra_v_flag_r <= 2'b00;
        end else begin
            low_v_flag_r   <= det_3v3_s
                            | (det_1v8_s & {2{~switch_variant_select}});
            extra_v_flag_r <= det_1v8_s & {2{switch_variant_select}};
        end
    end

endmodule // psw_card_power

// ### src/psw_sync.sv
// Two-flop synchroniser for a group of level inputs.
`timescale 1ns/100ps

module psw_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule // psw_sync
